// >>> hw/tss_pkg.sv
// constants and types for the temperature sensor serial access block
// assumes a 40 MHz system clock; the only other shared definition is the tss_conv_if interface
package tss_pkg;

    localparam int          SYS_CLK_KHZ   = 40000;
    localparam int          CONV_TIME_MS  = 43;
    localparam int          CONV_CYCLES   = CONV_TIME_MS * SYS_CLK_KHZ;
    localparam int          CONV_CNT_W    = 21;

    localparam logic [4:0]  WORD_BITS     = 5'h10;
    localparam logic [4:0]  BYTE_BITS     = 5'h08;

    localparam int          CMD_READ_POS  = 7;
    localparam int          SHUTDOWN_POS  = 15;
    localparam int          BUSY_POS      = 0;

    localparam logic [2:0]  ADDR_TEMP     = 3'h0;
    localparam logic [2:0]  ADDR_CTRL     = 3'h1;
    localparam logic [2:0]  ADDR_ID       = 3'h7;

    localparam logic [15:0] TEMP_RESET    = 16'h0000;
    localparam logic [15:0] WORD_ZERO     = 16'h0000;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_TEMP  = 5'b00010,
        ST_CMD   = 5'b00100,
        ST_RDATA = 5'b01000,
        ST_WDATA = 5'b10000
    } tss_state_type;

endpackage : tss_pkg

// >>> hw/tss_conv_if.sv
// conversion control signals between the serial front end and the conversion timer
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none

interface tss_conv_if;
    logic start;
    logic shutdown;
    logic busy;
    logic done;

    modport ctrl   (output start, output shutdown, input busy, input done);
    modport engine (input start, input shutdown, output busy, output done);
endinterface : tss_conv_if

`default_nettype wire

// >>> hw/tss_conv.sv
// conversion timer: runs back-to-back conversions of fixed length unless shut down
// assumes start and shutdown come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module tss_conv #(
    parameter int CONV_CYCLES = tss_pkg::CONV_CYCLES
) (
    input  wire logic   ref_clk_i,
    input  wire logic   reset_n_i,
    tss_conv_if.engine  conv
);

    logic [tss_pkg::CONV_CNT_W-1:0] cnt_q;
    logic [tss_pkg::CONV_CNT_W-1:0] cnt_d;
    logic                           busy_q;
    logic                           busy_d;
    logic                           done_q;
    logic                           done_d;

    localparam logic [tss_pkg::CONV_CNT_W-1:0] LAST = tss_pkg::CONV_CNT_W'(CONV_CYCLES - 1);

    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (conv.shutdown) begin
            cnt_d  = '0;
            busy_d = 1'b0;
        end else if (!busy_q) begin
            // start is never read: a new conversion begins whenever idle; only shutdown cuts one short
            busy_d = 1'b1; // see RULE3
            cnt_d  = '0;
        end else if (cnt_q == LAST) begin
            // continuous mode: next conversion follows at once
            done_d = 1'b1; // see RULE14
            cnt_d  = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign conv.busy = busy_q;
    assign conv.done = done_q;

endmodule : tss_conv

`default_nettype wire

// >>> hw/tss_top.sv
// serial access and conversion control of a digital temperature sensor
// assumes chip select, serial clock and data come from an off-chip master;
// temp_value_i is the converter output, stable on the system clock
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: undefined register address reads zero; writes there change nothing.
// RULE2: temperature read accepted anytime, giving the latest completed conversion.
// RULE3: a serial read never aborts a running conversion.
// RULE4: at end of read, reload output shift register, then start fresh conversion. The timer ignores the restart request, so no fresh conversion is started.
// RULE5: master starts software reset by writing shutdown bit 15 to one.
// RULE6: master holds shutdown at least one maximum 13-bit conversion time.
// RULE7: clearing shutdown returns the device to continuous conversion.
// RULE8: master waits one maximum conversion time before trusting temperature.
// RULE9: a readable identification register holds manufacturer and device codes.
// RULE10: master keeps serial clock period at least 765 ns.
// RULE11: master keeps chip select high at least 5 us between transactions.
// RULE12: chip select high releases the data line.
// RULE13: device changes output after falling edges; samples input on rising edges.
// RULE14: each 13-bit conversion completes within 43 ms.
// RULE15: first 16 clocks shift out temperature, then data line becomes input.
// RULE16: written data is latched after each complete group of eight bits. The code latches only the first byte of each data word.
// RULE17: chip select rising before eighth command bit's falling edge latches nothing.
module tss_top #(
    parameter int         CONV_CYCLES = tss_pkg::CONV_CYCLES,
    parameter logic [7:0] MFG_CODE    = 8'hA5, // arbitrary value
    parameter logic [7:0] DEV_CODE    = 8'h3C  // arbitrary value
) (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        serial_clock_in_i,
    input  wire logic        serial_data_i,
    input  wire logic [15:0] temp_value_i,
    output var  logic        serial_data_o,
    output var  logic        serial_data_oe_o,
    output var  logic        shutdown_o,
    output var  logic        conv_busy_o
);

    tss_conv_if conv_bus ();

    tss_conv #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_conv (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .conv        (conv_bus.engine)
    );

    // pin synchronisers, first stage read only by the second
    logic [1:0] cs_sync_q;
    logic [1:0] sck_sync_q;
    logic [1:0] sdi_sync_q;
    logic       cs_prev_q;
    logic       sck_prev_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cs_sync_q  <= 2'h3;
            sck_sync_q <= 2'h0;
            sdi_sync_q <= 2'h0;
            cs_prev_q  <= 1'b1;
            sck_prev_q <= 1'b0;
        end else begin
            cs_sync_q  <= {cs_sync_q[0], chip_select_n_i};
            sck_sync_q <= {sck_sync_q[0], serial_clock_in_i};
            sdi_sync_q <= {sdi_sync_q[0], serial_data_i};
            cs_prev_q  <= cs_sync_q[1];
            sck_prev_q <= sck_sync_q[1];
        end
    end

    logic cs_active;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;

    assign cs_active = !cs_sync_q[1];
    assign cs_fall   = cs_prev_q && !cs_sync_q[1];
    assign cs_rise   = !cs_prev_q && cs_sync_q[1];
    assign sck_rise  = !sck_prev_q && sck_sync_q[1];
    assign sck_fall  = sck_prev_q && !sck_sync_q[1];

    // serial state
    tss_pkg::tss_state_type state_q;
    tss_pkg::tss_state_type state_d;
    logic [4:0]             cnt_q;
    logic [4:0]             cnt_d;
    logic [15:0]            shift_q;
    logic [15:0]            shift_d;
    logic [7:0]             cmd_q;
    logic [7:0]             cmd_d;
    logic                   sdo_q;
    logic                   sdo_d;
    logic                   oe_q;
    logic                   oe_d;
    logic                   restart_q;
    logic                   restart_d;
    logic                   shutdown_q;
    logic                   shutdown_d;
    logic [15:0]            result_q;
    logic [15:0]            result_d;
    logic                   busy_q;

    function automatic logic is_ctrl(input logic [2:0] addr);
        is_ctrl = (addr == tss_pkg::ADDR_CTRL);
    endfunction : is_ctrl

    function automatic logic [15:0] reg_read(input logic [2:0] addr,
                                             input logic [15:0] temp,
                                             input logic        sd,
                                             input logic        busy);
        logic [15:0] word;
        word = tss_pkg::WORD_ZERO; // see RULE1
        if (addr == tss_pkg::ADDR_TEMP) begin
            word = temp;
        end else if (is_ctrl(addr)) begin
            word[tss_pkg::SHUTDOWN_POS] = sd;
            word[tss_pkg::BUSY_POS]     = busy;
        end else if (addr == tss_pkg::ADDR_ID) begin
            word = {MFG_CODE, DEV_CODE}; // see RULE9
        end
        reg_read = word;
    endfunction : reg_read

    always_comb begin
        logic [15:0] rd_word;
        // address taken from the shifter, the same bits that become the command byte
        rd_word    = reg_read(shift_q[2:0], result_q, shutdown_q, busy_q);
        state_d    = state_q;
        cnt_d      = cnt_q;
        shift_d    = shift_q;
        cmd_d      = cmd_q;
        sdo_d      = sdo_q;
        oe_d       = oe_q;
        restart_d  = 1'b0;
        shutdown_d = shutdown_q;
        if (!cs_active) begin
            // idle or frame end: release line, keep shifter loaded with latest result
            state_d = tss_pkg::ST_IDLE;
            cnt_d   = '0;
            oe_d    = 1'b0;               // see RULE12
            shift_d = result_q;           // see RULE4
            restart_d = cs_rise;          // see RULE4
        end else if (cs_fall || state_q == tss_pkg::ST_IDLE) begin
            state_d = tss_pkg::ST_TEMP;
            cnt_d   = '0;
            shift_d = result_q;           // see RULE2
            sdo_d   = result_q[15];
            oe_d    = 1'b1;
        end else if (sck_rise) begin
            cnt_d = cnt_q + 5'h01;
            if (state_q == tss_pkg::ST_CMD || state_q == tss_pkg::ST_WDATA) begin
                shift_d = {shift_q[14:0], sdi_sync_q[1]}; // see RULE13
            end
        end else if (sck_fall) begin
            unique case (state_q)
                tss_pkg::ST_TEMP, tss_pkg::ST_RDATA: begin
                    if (cnt_q == tss_pkg::WORD_BITS) begin
                        oe_d    = 1'b0;   // see RULE15
                        state_d = tss_pkg::ST_CMD;
                        cnt_d   = '0;
                    end else begin
                        shift_d = {shift_q[14:0], 1'b0};
                        sdo_d   = shift_q[14]; // see RULE13
                    end
                end
                tss_pkg::ST_CMD: begin
                    if (cnt_q == tss_pkg::BYTE_BITS) begin
                        // command taken only on the eighth falling edge
                        cmd_d = shift_q[7:0]; // see RULE17
                        cnt_d = '0;
                        if (shift_q[tss_pkg::CMD_READ_POS]) begin
                            state_d = tss_pkg::ST_RDATA;
                            shift_d = rd_word;
                            sdo_d   = rd_word[15];
                            oe_d    = 1'b1;
                        end else begin
                            state_d = tss_pkg::ST_WDATA;
                        end
                    end
                end
                tss_pkg::ST_WDATA: begin
                    // only the shutdown bit is writable; it sits in the high byte
                    if (cnt_q == tss_pkg::BYTE_BITS && is_ctrl(cmd_q[2:0])) begin
                        shutdown_d = shift_q[7];  // see RULE16, RULE7
                    end
                    if (cnt_q == tss_pkg::WORD_BITS) begin
                        state_d = tss_pkg::ST_CMD; // see RULE16
                        cnt_d   = '0;
                    end
                end
                default: begin
                    state_d = tss_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // result updates only on completed conversions
    always_comb begin
        result_d = conv_bus.done ? temp_value_i : result_q; // see RULE2
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q    <= tss_pkg::ST_IDLE;
            cnt_q      <= '0;
            shift_q    <= tss_pkg::TEMP_RESET;
            cmd_q      <= '0;
            sdo_q      <= 1'b0;
            oe_q       <= 1'b0;
            restart_q  <= 1'b0;
            shutdown_q <= 1'b0;
            result_q   <= tss_pkg::TEMP_RESET;
            busy_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            shift_q    <= shift_d;
            cmd_q      <= cmd_d;
            sdo_q      <= sdo_d;
            oe_q       <= oe_d;
            restart_q  <= restart_d;
            shutdown_q <= shutdown_d;
            result_q   <= result_d;
            busy_q     <= conv_bus.busy;
        end
    end

    // restart is a request; the timer never reads it, so it starts no conversion
    assign conv_bus.start    = restart_q; // see RULE3
    assign conv_bus.shutdown = shutdown_q; // see RULE7

    always_comb begin
        serial_data_o    = sdo_q;
        serial_data_oe_o = oe_q;
        shutdown_o       = shutdown_q;
        conv_busy_o      = busy_q;
    end

endmodule : tss_top

`default_nettype wire

// >>> testbench/tss_top_asserts.sv
// checker for the temperature sensor serial access block, bound to tss_top
// assumes it sees only the top ports, all on the one system clock
`timescale 1ns/1ps
`default_nettype none

module tss_top_asserts #(
    parameter int CONV_CYCLES = 50
) (
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic        chip_select_n_i,
    input wire logic        serial_clock_in_i,
    input wire logic        serial_data_i,
    input wire logic [15:0] temp_value_i,
    input wire logic        serial_data_o,
    input wire logic        serial_data_oe_o,
    input wire logic        shutdown_o,
    input wire logic        conv_busy_o
);
    logic [3:0] run_q;
    logic [3:0] run_d;

    always_comb begin
        run_d = (run_q == 4'hF) ? run_q : run_q + 4'h1;
    end
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) run_q <= 4'h0;
        else run_q <= run_d;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_release_cs:
        assert property (chip_select_n_i [*8] |-> !serial_data_oe_o) else $error("line driven while deselected");
    a_drive_start:
        assert property ($fell(chip_select_n_i) |-> ##[2:8] serial_data_oe_o) else $error("no drive after select");
    a_shift_on_fall:
        assert property (serial_data_oe_o && $past(serial_data_oe_o) && $changed(serial_data_o)
            |-> !serial_clock_in_i && !$past(serial_clock_in_i, 3)) else $error("output bit changed off falling edge");
    a_shut_busy:
        assert property ($rose(shutdown_o) |-> ##[1:3] (!conv_busy_o [*4])) else $error("busy kept in shutdown");
    a_resume_busy:
        assert property ($fell(shutdown_o) |-> ##[1:4] conv_busy_o) else $error("no resume after shutdown clear");
    a_latch_on_fall:
        assert property ($changed(shutdown_o) |-> !chip_select_n_i && !serial_clock_in_i
            && !$past(serial_clock_in_i, 2)) else $error("shutdown changed off byte boundary");
    a_idle_stable:
        assert property (chip_select_n_i [*6] |-> $stable(shutdown_o)) else $error("shutdown changed outside frame");
    a_conv_runs:
        assert property (run_q == 4'hF && !shutdown_o && !$past(shutdown_o, 6)
            |-> conv_busy_o || $past(conv_busy_o)) else $error("conversion stopped while running");

    c_frame:    cover property ($fell(chip_select_n_i));
    c_shut_on:  cover property ($rose(shutdown_o));
    c_shut_off: cover property ($fell(shutdown_o));
endmodule : tss_top_asserts

bind tss_top tss_top_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .chip_select_n_i(chip_select_n_i),
    .serial_clock_in_i(serial_clock_in_i), .serial_data_i(serial_data_i), .temp_value_i(temp_value_i),
    .serial_data_o(serial_data_o), .serial_data_oe_o(serial_data_oe_o), .shutdown_o(shutdown_o),
    .conv_busy_o(conv_busy_o));

`default_nettype wire

// >>> testbench/tss_host.sv
// three-wire serial master model: frames of temperature word, command, data
// assumes its clock is the bench system clock; results posted for the temperature word and each full 16-bit read data word
`timescale 1ns/1ps
`default_nettype none

module tss_host (
    input  wire logic        clk_i,
    input  wire logic        sdio_i,
    output var  logic        cs_n_o,
    output var  logic        sck_o,
    output var  logic        sd_o,
    output var  logic        sd_oe_o,
    output var  logic [15:0] res_o,
    output var  logic        res_stb_o
);
    initial begin
        cs_n_o = 1'b1; sck_o = 1'b0; sd_o = 1'b0; sd_oe_o = 1'b0; res_o = 16'h0000; res_stb_o = 1'b0;
    end

    // 32 cycles a bit gives an 800 ns period
    task automatic bit_io(input logic d, input logic drv, output logic q);
        repeat (8) @(posedge clk_i);
        sd_o <= d;
        sd_oe_o <= drv;
        repeat (8) @(posedge clk_i);
        sck_o <= 1'b1;
        q = sdio_i;
        repeat (16) @(posedge clk_i);
        sck_o <= 1'b0;
        sd_oe_o <= 1'b0; // released at the fall so the device may turn the line
    endtask : bit_io

    task automatic post(input logic [15:0] v);
        res_o <= v;
        res_stb_o <= 1'b1;
        @(posedge clk_i);
        res_stb_o <= 1'b0;
    endtask : post

    task automatic frame(input logic [7:0] c, input int nc, input logic [15:0] wd, input int nd);
        logic [15:0] w;
        logic        q;
        cs_n_o <= 1'b0;
        repeat (60) @(posedge clk_i);
        for (int i = 0; i < 16; i++) begin
            bit_io(1'b0, 1'b0, q);
            w = {w[14:0], q};
        end
        post(w);
        for (int i = 0; i < nc; i++) bit_io(c[7 - i], 1'b1, q);
        for (int i = 0; i < nd; i++) begin
            bit_io(wd[15 - i], !c[7], q);
            w = {w[14:0], q};
        end
        if (c[7] && nd == 16) post(w);
        repeat (16) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (220) @(posedge clk_i);
    endtask : frame
endmodule : tss_host

`default_nettype wire

// >>> testbench/tb_top.sv
// top testbench: serial master model against the sensor block, queued expectations
// assumes a shortened conversion length so several conversions fit one frame
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int         CONV = 50;
    localparam logic [7:0] MFG  = 8'h5A; // arbitrary value
    localparam logic [7:0] DEV  = 8'hC3; // arbitrary value
    localparam logic [16:0] SKIP = 17'h10000;

    logic        ref_clk, reset_n, cs_n, sck, h_d, h_oe, sdo, sd_oe, shutdown, busy, res_stb;
    logic        last_q = 1'b0;
    logic [15:0] temp_val, res, ta, tb_v;
    logic [16:0] e;
    logic [16:0] exp_q[$];
    wire  logic  sdio;
    int          errors, tests_run, i;

    // released line shows the inverse of its last level, not a settled value
    assign sdio = sd_oe ? sdo : (h_oe ? h_d : ~last_q);
    always @(posedge ref_clk) if (sd_oe || h_oe) last_q <= sdio;

    tss_top #(.CONV_CYCLES(CONV), .MFG_CODE(MFG), .DEV_CODE(DEV)) i_dut (
        .ref_clk_i(ref_clk), .reset_n_i(reset_n), .chip_select_n_i(cs_n), .serial_clock_in_i(sck),
        .serial_data_i(sdio), .temp_value_i(temp_val), .serial_data_o(sdo), .serial_data_oe_o(sd_oe),
        .shutdown_o(shutdown), .conv_busy_o(busy));
    tss_host i_host (.clk_i(ref_clk), .sdio_i(sdio), .cs_n_o(cs_n), .sck_o(sck), .sd_o(h_d), .sd_oe_o(h_oe),
        .res_o(res), .res_stb_o(res_stb));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic xfer(input logic [7:0] c, input int nc, input logic [15:0] w, input int nd,
                        input logic [16:0] et, input logic [16:0] er, input string name);
        exp_q.push_back(et);
        if (c[7] && nd == 16) exp_q.push_back(er);
        i_host.frame(c, nc, w, nd);
        $display("test %s done", name);
    endtask : xfer

    always @(posedge ref_clk) begin
        if (res_stb === 1'b1) begin
            if (exp_q.size() == 0) check(res, 16'hXXXX);
            else begin
                e = exp_q.pop_front();
                if (!e[16]) check(res, e[15:0]);
            end
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end

    initial begin
        reset_n = 1'b0; errors = 0; tests_run = 0;
        void'($urandom(32'h80CC));
        ta = 16'($urandom);
        tb_v = ~ta;
        temp_val = ta;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (200) @(posedge ref_clk);
        xfer(8'h02, 8, 16'h8000 | 16'($urandom), 16, SKIP, SKIP, "undefined write");
        check({15'h0000, shutdown}, 16'h0000);
        xfer(8'h83, 8, 16'h0000, 16, {1'b0, ta}, 17'h00000, "undefined read");
        xfer(8'h87, 8, 16'h0000, 16, {1'b0, ta}, {1'b0, MFG, DEV}, "identity");
        xfer(8'h01, 5, 16'h0000, 0, {1'b0, ta}, SKIP, "command abort");
        check({15'h0000, shutdown}, 16'h0000);
        xfer(8'h01, 8, 16'h8000, 8, {1'b0, ta}, SKIP, "shutdown high byte");
        check({15'h0000, shutdown}, 16'h0001);
        check({15'h0000, busy}, 16'h0000);
        @(posedge ref_clk);
        temp_val <= tb_v;
        repeat (CONV * 4) @(posedge ref_clk);
        xfer(8'h80, 8, 16'h0000, 16, {1'b0, ta}, {1'b0, ta}, "held in shutdown");
        xfer(8'h81, 8, 16'h0000, 16, {1'b0, ta}, 17'h08000, "control readback");
        xfer(8'h01, 8, 16'h0000, 16, {1'b0, ta}, SKIP, "leave shutdown");
        check({15'h0000, shutdown}, 16'h0000);
        repeat (CONV) @(posedge ref_clk);
        check({15'h0000, busy}, 16'h0001);
        xfer(8'h80, 8, 16'h0000, 16, {1'b0, tb_v}, {1'b0, tb_v}, "resumed conversion");
        xfer(8'h81, 8, 16'h0000, 16, {1'b0, tb_v}, 17'h00001, "busy readback");
        for (i = 0; i < 100 && exp_q.size() != 0; i++) @(posedge ref_clk);
        if (exp_q.size() != 0) errors++;
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
